/* logic/scac_pkg.sv */
`default_nettype none
package scac_pkg;
    // word width held by both arrays, any source width
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned D_WORDS    = 256;   // data array depth
    localparam int unsigned I_WORDS    = 1024;  // instruction array depth
    localparam int unsigned TAG_W      = 30;    // address bits 31:2
    localparam int unsigned BOFS_W     = 2;     // byte offset in word
    localparam int unsigned LOFS_W     = 2;     // word offset in line
    // on-chip register window, uncached by decode
    localparam logic [31:0] IO_BASE    = 32'hfff0_0000;
    localparam logic [31:0] IO_MASK    = 32'hfff0_0000;
    // access sizes
    localparam logic [1:0]  SZ_BYTE    = 2'h0;
    localparam logic [1:0]  SZ_HALF    = 2'h1;
    localparam logic [1:0]  SZ_WORD    = 2'h2;
    localparam logic [3:0]  BE_ALL     = 4'hf;
    localparam logic [3:0]  BE_NONE    = 4'h0;
    localparam logic [1:0]  WIDX_LAST  = 2'h3;
    localparam logic [1:0]  WIDX_FIRST = 2'h0;
    // half-cycle phases
    localparam logic        PH_FIRST   = 1'b0;
    localparam logic        PH_SECOND  = 1'b1;

    typedef enum logic [5:0] {
        ST_RUN    = 6'h01,
        ST_DMISS  = 6'h02,
        ST_DFIX   = 6'h04,
        ST_IMISS  = 6'h08,
        ST_STREAM = 6'h10,
        ST_REFILL = 6'h20
    } scac_state_e;

    // data reference from the core
    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  size;
        logic        uncached;
        logic [31:0] addr;
        logic [31:0] wdata;
    } scac_dreq_s;

    // request to the bus interface unit
    typedef struct packed {
        logic        rd_req;
        logic        block;
        logic        wr_req;
        logic [3:0]  be;
        logic [31:0] addr;
        logic [31:0] wdata;
    } scac_biu_s;
endpackage
`default_nettype wire

/* logic/scac_ctrl.sv */
// Notes on behaviour
// - first half: data address, finish instruction read
// - second half: data access, next instruction address
// - both hit, no stall: advance, run cycle
// - arrays hold full 32-bit words
// - tag mismatch or uncacheable means miss
// - data miss served before instruction miss
// - stall until bus unit returns data
// - fixup forwards and writes data together
// - fixup re-addresses caches, reissues access
// - uncacheable fixup skips cache write
// - refill per word, execute at missed word
// - stream ends at block end or events
// - after early stop, finish refilling line
// - uncacheable references bypass the cache, except data references while isolated
// - on-chip register window always uncacheable
// - swap bit exchanges array roles
// - isolate: no memory stores, loads hit
// - miss flag tracks latest load, even isolated
// - isolated partial store clears line valid
// - partial store: miss memory only, hit merges
// - instruction lines four words, data one word
`timescale 1ns/1ps
`default_nettype none
module scac_ctrl (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                swap_cache_bit,
    input  wire logic                isolate_cache_bit,
    input  wire logic [31:0]         i_addr,
    input  wire logic                i_uncached,
    input  wire scac_pkg::scac_dreq_s d_req,
    input  wire logic                taken_branch,
    input  wire logic                internal_stall,
    input  wire logic                exception_evt,
    input  wire logic                biu_ack,
    input  wire logic [31:0]         biu_rdata,
    output scac_pkg::scac_biu_s      biu_req,
    output logic                     run,
    output logic                     stall,
    output logic                     fixup,
    output logic                     phase,
    output logic [31:0]              instr_data,
    output logic [31:0]              load_data,
    output logic                     cache_miss_flag
);
    import scac_pkg::*;

    localparam int unsigned DIX_W = $clog2(D_WORDS);
    localparam int unsigned IIX_W = $clog2(I_WORDS);

    // storage: flip-flops, data array is 0, instruction array is 1
    // full words whatever the memory width
    logic [WORD_W-1:0] dat0_ff [D_WORDS];
    logic [TAG_W-1:0]  tag0_ff [D_WORDS];
    logic [D_WORDS-1:0] val0_ff;
    logic [WORD_W-1:0] dat1_ff [I_WORDS];
    logic [TAG_W-1:0]  tag1_ff [I_WORDS];
    logic [I_WORDS-1:0] val1_ff;

    scac_state_e state_ff;          // controller state
    logic        phase_ff;          // half-cycle phase
    logic        seen_ph0_ff;       // first half done in this run
    logic [31:0] i_addr_ff;         // instruction address in use
    logic        i_unc_ff;          // its uncached attribute
    scac_dreq_s  d_ff;              // data reference in use
    logic        imiss_ff;          // instruction lookup missed
    logic        pend_imiss_ff;     // instruction miss behind data miss
    logic [31:0] fix_data_ff;       // word returned for data fixup
    logic        fix_done_ff;       // fixup write already made
    logic [1:0]  widx_ff;           // word of the block arriving
    scac_biu_s   biu_ff;
    logic [31:0] instr_data_ff;
    logic [31:0] load_data_ff;
    logic        cache_miss_flag_ff;

    // write port into the arrays
    logic        wr_en;
    logic        wr_inval;
    logic        wr_role_i;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;

    // uncacheable decode, shared by both references
    function automatic logic is_unc(input logic flag, input logic [31:0] a);
        return flag | ((a & IO_MASK) == IO_BASE);
    endfunction

    // byte enables from size and low address
    function automatic logic [3:0] be_of(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] be;
        be = BE_ALL;
        if (sz == SZ_BYTE) begin
            be = 4'(4'h1 << a);
        end else if (sz == SZ_HALF) begin
            be = 4'(4'h3 << {a[1], 1'b0});
        end
        return be;
    endfunction

    // merge stored bytes into the cached word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // lookup by role: {hit, word}; swap picks the physical array
    function automatic logic [32:0] cache_look(input logic role_i, input logic [31:0] a);
        logic [DIX_W-1:0] dx;
        logic [IIX_W-1:0] ix;
        logic [32:0]      r;
        dx = a[BOFS_W +: DIX_W];
        ix = a[BOFS_W +: IIX_W];
        if (role_i ^ swap_cache_bit) begin
            r = {val1_ff[ix] && (tag1_ff[ix] == a[31:BOFS_W]), dat1_ff[ix]};
        end else begin
            r = {val0_ff[dx] && (tag0_ff[dx] == a[31:BOFS_W]), dat0_ff[dx]};
        end
        return r;
    endfunction

    logic [32:0] i_look;
    logic [32:0] d_look;
    logic [32:0] raw_look;
    logic        i_unc;
    logic        d_unc;
    logic        d_load;
    logic        dmiss_c;
    logic        run_c;
    logic        stop_c;
    logic [3:0]  st_be;
    logic [31:0] st_word;

    // lookups sit in a process so array and swap changes re-evaluate them;
    // a plain assign would only wake on the address argument
    always_comb begin
        i_look   = cache_look(1'b1, i_addr_ff);
        d_look   = cache_look(1'b0, d_ff.addr);
        raw_look = cache_look(1'b0, d_req.addr);
    end
    assign i_unc    = is_unc(i_unc_ff, i_addr_ff);
    assign d_unc    = is_unc(d_ff.uncached, d_ff.addr);
    assign d_load   = d_ff.req & ~d_ff.we;
    assign st_be    = be_of(d_ff.size, d_ff.addr[1:0]);
    assign st_word  = merge(d_look[31:0], d_ff.wdata, st_be);
    // isolated loads always hit; else tag or uncached
    assign dmiss_c  = d_load & ~isolate_cache_bit & (d_unc | ~d_look[32]);
    // events that end a stream, incl. a data miss
    assign stop_c   = taken_branch | internal_stall | exception_evt
                    | (d_req.req & ~d_req.we
                       & (is_unc(d_req.uncached, d_req.addr) | ~raw_look[32]));

    // run cycle: both caches hit in the second half, a fixup ends, or a missed fetch word arrives
    always_comb begin
        run_c = 1'b0;
        if (state_ff == ST_RUN) begin
            run_c = (phase_ff == PH_SECOND) & seen_ph0_ff & ~dmiss_c & ~imiss_ff;
        end else if (state_ff == ST_DFIX) begin
            run_c = (phase_ff == PH_SECOND) & fix_done_ff & ~pend_imiss_ff;
        end else if (biu_ack & ((state_ff == ST_IMISS) | (state_ff == ST_STREAM))) begin
            // execute from the missed word on
            run_c = i_unc | (state_ff == ST_STREAM) | (widx_ff == i_addr_ff[3:2]);
            run_c = run_c & ~((state_ff == ST_STREAM) & stop_c);
        end
    end

    // array write port: stores, fixups and refills
    always_comb begin
        wr_en     = 1'b0;
        wr_inval  = 1'b0;
        wr_role_i = 1'b0;
        wr_addr   = d_ff.addr;
        wr_data   = d_ff.wdata;
        if (run_c && state_ff == ST_RUN && d_ff.req && d_ff.we) begin
            if (isolate_cache_bit) begin
                // full store fills; partial clears valid
                wr_en    = 1'b1;
                wr_inval = (d_ff.size != SZ_WORD);
            end else if (!d_unc && (d_ff.size == SZ_WORD || d_look[32])) begin
                // partial store updates cache only on hit
                wr_en   = 1'b1;
                wr_data = st_word;
            end
        end else if (state_ff == ST_DFIX && !fix_done_ff) begin
            // written in the cycle it is forwarded; not if uncached
            wr_en   = ~d_unc;
            wr_data = fix_data_ff;
        end else if (biu_ack && !i_unc && (state_ff == ST_IMISS ||
                     state_ff == ST_STREAM || state_ff == ST_REFILL)) begin
            // each block word written as it arrives
            wr_en     = 1'b1;
            wr_role_i = 1'b1;
            wr_addr   = {i_addr_ff[31:4], widx_ff, 2'h0};
            wr_data   = biu_rdata;
        end
    end

    // data-role array (physical array 0 unless swapped)
    always_ff @(posedge clk) begin
        if (!nrst) begin
            val0_ff <= '0;
        end else if (wr_en && !(wr_role_i ^ swap_cache_bit)) begin
            // one word lines
            if (wr_inval) begin
                val0_ff[wr_addr[BOFS_W +: DIX_W]] <= 1'b0;
            end else begin
                val0_ff[wr_addr[BOFS_W +: DIX_W]] <= 1'b1;
                dat0_ff[wr_addr[BOFS_W +: DIX_W]] <= wr_data;
                tag0_ff[wr_addr[BOFS_W +: DIX_W]] <= wr_addr[31:BOFS_W];
            end
        end
    end

    // instruction-role array; four-word lines, a tag per word
    always_ff @(posedge clk) begin
        if (!nrst) begin
            val1_ff <= '0;
        end else if (wr_en && (wr_role_i ^ swap_cache_bit)) begin
            if (wr_inval) begin
                // the whole four-word line goes invalid
                for (int w = 0; w < 4; w++) begin
                    val1_ff[{wr_addr[BOFS_W+LOFS_W +: IIX_W-LOFS_W], 2'(w)}] <= 1'b0;
                end
            end else begin
                val1_ff[wr_addr[BOFS_W +: IIX_W]] <= 1'b1;
                dat1_ff[wr_addr[BOFS_W +: IIX_W]] <= wr_data;
                tag1_ff[wr_addr[BOFS_W +: IIX_W]] <= wr_addr[31:BOFS_W];
            end
        end
    end

    // half-cycle phase; one core clock is two clk cycles
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_ff <= PH_FIRST;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    // first half in run: latch data ref, finish instruction read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            d_ff          <= '0;
            imiss_ff      <= 1'b0;
            seen_ph0_ff   <= 1'b0;
            instr_data_ff <= '0;
        end else if (state_ff == ST_RUN && phase_ff == PH_FIRST) begin
            // data address presented, instruction read completed
            d_ff          <= d_req;
            instr_data_ff <= i_look[31:0];
            imiss_ff      <= ~i_look[32] | i_unc;
            seen_ph0_ff   <= 1'b1;
        end else if (state_ff == ST_DFIX && !fix_done_ff) begin
            instr_data_ff <= i_look[31:0];
        end else if (biu_ack && run_c) begin
            // streamed or bypassed word straight to the core
            instr_data_ff <= biu_rdata;
        end else if (state_ff != ST_RUN) begin
            seen_ph0_ff   <= 1'b0;
        end
    end

    // next instruction address taken when the pipe advances
    always_ff @(posedge clk) begin
        if (!nrst) begin
            i_addr_ff <= '0;
            i_unc_ff  <= 1'b0;
        end else if (run_c && state_ff != ST_IMISS && state_ff != ST_STREAM) begin
            // instruction cache addressed with next address
            i_addr_ff <= i_addr;
            i_unc_ff  <= i_uncached;
        end else if (state_ff == ST_IMISS && biu_ack && i_unc) begin
            // bypassed fetch delivered, pipe moves to next address
            i_addr_ff <= i_addr;
            i_unc_ff  <= i_uncached;
        end else if (state_ff == ST_REFILL && biu_ack && widx_ff == WIDX_LAST) begin
            i_addr_ff <= i_addr;
            i_unc_ff  <= i_uncached;
        end else if (state_ff == ST_STREAM && biu_ack && widx_ff == WIDX_LAST) begin
            i_addr_ff <= i_addr;
            i_unc_ff  <= i_uncached;
        end
    end

    // load data and the miss flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            load_data_ff       <= '0;
            cache_miss_flag_ff <= 1'b0;
        end else if (run_c && state_ff == ST_RUN && d_load) begin
            // data read in second half; flag even when isolated
            load_data_ff       <= d_look[31:0];
            cache_miss_flag_ff <= ~d_look[32] | d_unc;
        end else if (state_ff == ST_DFIX && !fix_done_ff) begin
            // returned word forwarded to the core
            load_data_ff       <= fix_data_ff;
            cache_miss_flag_ff <= 1'b1;
        end
    end

    // main state machine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff      <= ST_RUN;
            pend_imiss_ff <= 1'b0;
            fix_data_ff   <= '0;
            fix_done_ff   <= 1'b0;
            widx_ff       <= WIDX_FIRST;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    fix_done_ff <= 1'b0;
                    widx_ff     <= WIDX_FIRST;
                    if (phase_ff == PH_SECOND && seen_ph0_ff && dmiss_c) begin
                        // data miss first, instruction miss remembered
                        state_ff      <= ST_DMISS;
                        pend_imiss_ff <= imiss_ff;
                    end else if (phase_ff == PH_SECOND && seen_ph0_ff && imiss_ff) begin
                        state_ff <= ST_IMISS;
                    end
                end
                ST_DMISS: begin
                    // stall until the bus unit returns the word
                    if (biu_ack) begin
                        fix_data_ff <= biu_rdata;
                        state_ff    <= ST_DFIX;
                    end
                end
                ST_DFIX: begin
                    fix_done_ff <= 1'b1;
                    if (phase_ff == PH_SECOND && fix_done_ff) begin
                        state_ff      <= pend_imiss_ff ? ST_IMISS : ST_RUN;
                        pend_imiss_ff <= 1'b0;
                    end
                end
                ST_IMISS: begin
                    if (biu_ack) begin
                        widx_ff <= widx_ff + 2'h1;
                        if (i_unc || widx_ff == WIDX_LAST) begin
                            // bypassed single word, or block done
                            state_ff <= ST_RUN;
                        end else if (widx_ff == i_addr_ff[3:2]) begin
                            state_ff <= ST_STREAM;
                        end
                    end
                end
                ST_STREAM: begin
                    if (biu_ack) begin
                        widx_ff <= widx_ff + 2'h1;
                        // stream to block end or until an event
                        if (widx_ff == WIDX_LAST) begin
                            state_ff <= ST_RUN;
                        end else if (stop_c) begin
                            state_ff <= ST_REFILL;
                        end
                    end
                end
                ST_REFILL: begin
                    if (biu_ack) begin
                        widx_ff <= widx_ff + 2'h1;
                        if (widx_ff == WIDX_LAST) begin
                            state_ff <= ST_RUN;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // bus requests: reads held as a level, stores a one-clk pulse
    always_ff @(posedge clk) begin
        if (!nrst) begin
            biu_ff <= '0;
        end else begin
            biu_ff.wr_req <= 1'b0;
            if (run_c && state_ff == ST_RUN && d_ff.req && d_ff.we && !isolate_cache_bit) begin
                // write through; isolated stores never leave
                biu_ff.wr_req <= 1'b1;
                biu_ff.addr   <= d_ff.addr;
                // a merged hit goes out as a full word
                biu_ff.be     <= (!d_unc && d_look[32]) ? BE_ALL : st_be;
                biu_ff.wdata  <= (!d_unc && d_look[32]) ? st_word : d_ff.wdata;
                biu_ff.rd_req <= 1'b0;
            end else if (state_ff == ST_RUN && phase_ff == PH_SECOND && seen_ph0_ff
                         && (dmiss_c || imiss_ff)) begin
                // miss handed to memory; data side wins
                biu_ff.rd_req <= 1'b1;
                biu_ff.be     <= BE_ALL;
                biu_ff.block  <= ~dmiss_c & ~i_unc;
                biu_ff.addr   <= dmiss_c ? d_ff.addr
                               : (i_unc ? i_addr_ff : {i_addr_ff[31:4], 4'h0});
            end else if (state_ff == ST_DFIX && phase_ff == PH_SECOND && fix_done_ff
                         && pend_imiss_ff) begin
                // four-word block read for the instruction line, one word if uncached
                biu_ff.rd_req <= 1'b1;
                biu_ff.block  <= ~i_unc;
                biu_ff.addr   <= i_unc ? i_addr_ff : {i_addr_ff[31:4], 4'h0};
            end else if (biu_ack && (state_ff == ST_DMISS || i_unc
                         || widx_ff == WIDX_LAST)) begin
                biu_ff.rd_req <= 1'b0;
                biu_ff.block  <= 1'b0;
            end
        end
    end

    assign biu_req         = biu_ff;
    assign run             = run_c;
    // stall whenever a miss holds the pipe
    assign stall           = (state_ff != ST_RUN) & ~run_c;
    assign fixup           = (state_ff == ST_DFIX) | (biu_ack & run_c);
    assign phase           = phase_ff;
    assign instr_data      = instr_data_ff;
    assign load_data       = load_data_ff;
    assign cache_miss_flag = cache_miss_flag_ff;
endmodule
`default_nettype wire

/* verif/scac_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module scac_chk
    import scac_pkg::*;
(
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                biu_ack,
    input wire scac_pkg::scac_biu_s biu_req,
    input wire logic                run,
    input wire logic                stall,
    input wire logic                fixup,
    input wire logic                phase
);
    logic [1:0] acks_ff;                      // words returned in the open read
    wire logic  rd  = biu_req.rd_req;         // read outstanding
    wire logic  blk = biu_req.block;          // four-word read
    wire logic  last = blk && biu_ack && acks_ff == 2'h3;  // fourth word arrives
    // clears between reads, so every block counts from zero
    always_ff @(posedge clk) begin
        if (!nrst || !rd) acks_ff <= 2'h0;
        else if (biu_ack) acks_ff <= acks_ff + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    run_half_a: assert property (run && !biu_ack |-> phase == PH_SECOND) else $error("run phase");
    run_stall_a: assert property (run |-> !stall) else $error("run stall");
    miss_stall_a: assert property ($rose(rd) |-> stall) else $error("no stall");
    rd_hold_a: assert property (rd && !biu_ack |=> rd) else $error("read dropped");
    rd_done_a: assert property (rd && !blk && biu_ack |=> !rd) else $error("read stuck");
    ack_fix_a: assert property (rd && !blk && biu_ack |-> ##[0:1] fixup) else $error("no fix");
    blk_end_a: assert property (rd && last |=> !rd) else $error("block length");
    wr_pulse_a: assert property (biu_req.wr_req |=> !biu_req.wr_req) else $error("wr long");
    cover property (run);
    cover property (rd && last);
    cover property (biu_req.wr_req);
endmodule
bind scac_ctrl scac_chk u_chk (.clk(clk), .nrst(nrst), .biu_ack(biu_ack), .biu_req(biu_req),
    .run(run), .stall(stall), .fixup(fixup), .phase(phase));
`default_nettype wire

/* verif/scac_biu_mdl.sv */
`timescale 1ns/1ps
`default_nettype none
// bus unit stand-in: first word comes lat idle clocks after the request, each later word lat+1 after the last
module scac_biu_mdl
    import scac_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire scac_pkg::scac_biu_s biu_req,
    input  wire logic [3:0]          lat,
    output logic                     biu_ack,
    output logic [31:0]              biu_rdata
);
    logic [3:0]  wait_ff;  // idle clocks so far
    logic [1:0]  word_ff;  // next word of a block
    logic [15:0] lo;       // word value comes from its address
    assign lo = {biu_req.addr[15:4], biu_req.block ? word_ff : biu_req.addr[3:2], 2'h0};
    // one ack per word, block words in order
    always_ff @(posedge clk) begin
        biu_ack   <= 1'b0;
        // data inverts every clock between words, so a stale word matches again every second clock
        biu_rdata <= ~biu_rdata;
        if (!nrst || !biu_req.rd_req) begin
            wait_ff <= 4'h0;
            word_ff <= 2'h0;
        end else if (biu_ack) begin
            wait_ff <= 4'h0;
        end else if (wait_ff != lat) begin
            wait_ff <= wait_ff + 4'h1;
        end else begin
            biu_ack   <= 1'b1;
            biu_rdata <= {~lo, lo};
            word_ff   <= word_ff + 2'h1;
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scac_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        swap_cache_bit = 1'b0;   // roles stay unswapped
    logic        isolate_cache_bit = 1'b0;
    logic        i_uncached = 1'b0;
    logic        quiet = 1'b0;            // no stream stop events
    logic [31:0] i_addr = 32'h0000_0100;  // fetch stays on one line
    logic [3:0]  lat = 4'h3;              // bus answer delay
    scac_dreq_s  d_req = '0;
    scac_biu_s   biu_req;
    logic        biu_ack, run, stall, fixup, phase, cache_miss_flag, rd_prev;
    logic [31:0] biu_rdata, instr_data, load_data;
    logic [31:0] rd_log [0:15];           // addresses of new reads
    int          n_rd = 0;
    int          n_wr = 0;
    int          n_errors = 0;
    int          checks_done = 0;

    always #2.5 clk = ~clk;
    scac_ctrl uut (
        .clk               (clk),
        .nrst              (nrst),
        .swap_cache_bit    (swap_cache_bit),
        .isolate_cache_bit (isolate_cache_bit),
        .i_addr            (i_addr),
        .i_uncached        (i_uncached),
        .d_req             (d_req),
        .taken_branch      (quiet),
        .internal_stall    (quiet),
        .exception_evt     (quiet),
        .biu_ack           (biu_ack),
        .biu_rdata         (biu_rdata),
        .biu_req           (biu_req),
        .run               (run),
        .stall             (stall),
        .fixup             (fixup),
        .phase             (phase),
        .instr_data        (instr_data),
        .load_data         (load_data),
        .cache_miss_flag   (cache_miss_flag)
    );
    scac_biu_mdl mdl (
        .clk       (clk),
        .nrst      (nrst),
        .biu_req   (biu_req),
        .lat       (lat),
        .biu_ack   (biu_ack),
        .biu_rdata (biu_rdata)
    );

    // log each new read and every store on the bus
    always @(posedge clk) begin
        rd_prev <= biu_req.rd_req;
        if (biu_req.wr_req === 1'b1) n_wr <= n_wr + 1;
        if (biu_req.rd_req === 1'b1 && rd_prev !== 1'b1) begin
            rd_log[n_rd[3:0]] <= biu_req.addr;
            n_rd <= n_rd + 1;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // returns at the edge that closes a run cycle in which the data side
    // commits; streamed runs are skipped unless fetch is uncached
    task automatic wait_run;
        for (int n = 0; n < 300; n++) begin
            @(posedge clk);
            if (run === 1'b1 && (biu_ack !== 1'b1 || i_uncached === 1'b1)) return;
        end
        n_errors++;
        report_and_stop;
    endtask

    // finish the pending reference, then idle the data side
    task automatic go;
        wait_run;
        d_req.req <= 1'b0;
        #1;
    endtask

    task automatic acc(input logic we, input logic [1:0] sz, input logic unc,
                       input logic [31:0] a, input logic [31:0] wd);
        wait_run;
        d_req <= '{1'b1, we, sz, unc, a, wd};
        go;
    endtask

    initial begin
        d_req <= '{1'b1, 1'b0, SZ_WORD, 1'b0, 32'h40, 32'h0};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // the first core cycle latches the load, then the side goes idle
        @(posedge clk);
        d_req.req <= 1'b0;
        go;
        chk("first read", rd_log[0], 32'h40);
        chk("block read", rd_log[1], 32'h0);
        chk("next block", rd_log[2], 32'h100);
        chk("load", load_data, 32'hffbf_0040);
        chk("streamed", instr_data, 32'hfeff_0100);
        chk("miss", cache_miss_flag, 1);
        lat <= 4'h0;
        acc(0, SZ_WORD, 0, 32'h40, 0);
        chk("hit", cache_miss_flag, 0);
        acc(1, SZ_WORD, 0, 32'h44, 32'h1234_5678);
        acc(0, SZ_WORD, 0, 32'h44, 0);
        chk("stored", load_data, 32'h1234_5678);
        acc(1, SZ_BYTE, 0, 32'h80, 0);
        acc(0, SZ_WORD, 0, 32'h80, 0);
        chk("part miss", cache_miss_flag, 1);
        chk("writes", n_wr, 2);
        acc(0, SZ_WORD, 1, 32'h44, 0);
        chk("bypass", load_data, 32'hffbb_0044);
        acc(0, SZ_WORD, 0, 32'h44, 0);
        chk("no fill", load_data, 32'h1234_5678);
        acc(0, SZ_WORD, 0, IO_BASE | 32'h44, 0);
        acc(0, SZ_WORD, 0, IO_BASE | 32'h44, 0);
        chk("reads", n_rd, 7);
        wait_run;
        i_uncached <= 1'b1;
        repeat (5) wait_run;
        isolate_cache_bit <= 1'b1;
        repeat (5) wait_run;
        i_uncached <= 1'b0;
        acc(1, SZ_WORD, 0, 32'h200, 32'hcafe_f00d);
        acc(0, SZ_WORD, 0, 32'h600, 0);
        chk("iso miss", cache_miss_flag, 1);
        acc(0, SZ_WORD, 0, 32'h200, 0);
        chk("iso data", load_data, 32'hcafe_f00d);
        chk("iso hit", cache_miss_flag, 0);
        // flush style invalidate by isolated byte store
        acc(1, SZ_BYTE, 0, 32'h200, 0);
        acc(0, SZ_WORD, 0, 32'h200, 0);
        chk("iso clear", cache_miss_flag, 1);
        chk("iso writes", n_wr, 2);
        // uncached fetch again before leaving isolation
        wait_run;
        i_uncached <= 1'b1;
        repeat (5) wait_run;
        isolate_cache_bit <= 1'b0;
        repeat (5) wait_run;
        i_uncached <= 1'b0;
        report_and_stop;
    end
endmodule
`default_nettype wire
